// ### lvs_pkg.sv
// shared constants and types for the low-voltage detect / standby block
// assumes a 32-bit APB master and an analog comparator bank outside
package lvs_pkg;

    // ****************************************
    // register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [31:0] IDX_LV_CTRL = 32'h0000F730;
    localparam logic [31:0] IDX_LV_STATUS = 32'h0000F731;
    localparam logic [31:0] IDX_P7_DATA = 32'h0000FFDA;
    localparam logic [31:0] IDX_P1_FUNC = 32'h0000FFE0;
    localparam logic [31:0] IDX_P7_DIR = 32'h0000FFEA;
    localparam logic [31:0] IDX_SBY_CTRL1 = 32'h000FFFF0;
    localparam logic [31:0] IDX_SBY_CTRL2 = 32'h000FFFF1;
    localparam logic [31:0] IDX_EVT_STATUS = 32'h000FFF80;
    localparam logic [31:0] IDX_EVT_ENABLE = 32'h000FFF81;
    localparam logic [31:0] IDX_EVT_CLEAR = 32'h000FFF82;
    localparam logic [31:0] IDX_SLEEP_CMD = 32'h000FFF83;
    localparam logic [31:0] IDX_MODE_STAT = 32'h000FFF84;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_DET_EN = 7;
    localparam int BIT_LVL_SEL = 3;
    localparam int BIT_RST_EN = 2;
    localparam int BIT_FALL_IE = 1;
    localparam int BIT_RISE_IE = 0;
    localparam int BIT_FALL_FLAG = 1;
    localparam int BIT_RISE_FLAG = 0;
    localparam int BIT_LED = 4;
    localparam int BIT_P15_FUNC = 5;
    localparam int BIT_SOFT_STANDBY_SELECT = 7;
    localparam int BIT_STS_HI = 6;
    localparam int BIT_STS_LO = 4;
    localparam int BIT_DIRECT_TRANSFER_FLAG = 5;
    localparam int EVT_FALL = 0;
    localparam int EVT_RISE = 1;
    localparam int EVT_STANDBY = 2;
    localparam int EVT_WAKE = 3;
    localparam int EVT_W = 4;

    localparam int PRESCALE_W = 13;
    localparam int WAIT_W = 21;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] STS_BASE_SEL = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic below_fall;     // supply at or below 3.7 V
        logic above_rise;     // supply at or above 4.0 V
        logic below_rst_lo;   // supply at or below 2.3 V
        logic below_rst_hi;   // supply at or below 3.6 V
    } lvs_cmp_s;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b01,
        DET_ACTIVE = 2'b10
    } lvs_det_e;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'b001,
        PWR_STANDBY = 3'b010,
        PWR_WAKING = 3'b100
    } lvs_pwr_e;

endpackage

// ### lvs_top.sv
// low-voltage detect control/status, standby entry and port setup
// assumes comparator levels synchronous to pclk and one APB master
// How it works
// - 13-bit prescaler counts up by one every clock
// - control bit 7 enables detector; cleared keeps it idle
// - control bit 3 selects reset threshold: 0 low level, 1 high level
// - control bit 2 lets an under-threshold supply assert internal reset
// - control bit 1 enables interrupt on supply fall
// - control bit 0 enables interrupt on supply rise
// - status bit 1 sets when supply drops to fall level
// - status bit 0 sets on fall then recovery, rise enabled, before reset level
// - software clears the flags; handler clears its cause before return
// - fall or rise request drives the single external interrupt zero
// - rise request during standby wakes the device to active
// - port 7 data bit 4 sets the LED output level
// - port 7 direction bit 4 makes the LED pin output
// - port 1 mode bit 5 picks shared pin function; clear means port pin
// - sleep in active with soft standby set, direct transfer clear, enters standby
// - standby wait select bits set wake wait; pattern 100 gives 131072
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module lvs_top #(
    // wake wait is 2**(sel + WAIT_BASE_LOG2) cycles; shorten for simulation
    parameter int WAIT_BASE_LOG2 = 13
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparators
    input wire lvs_pkg::lvs_cmp_s supply_cmp,
    // cpu side
    input wire logic sleep_exec,
    output logic undervolt_reset,
    output logic ext_interrupt_zero,
    output logic standby_mode,
    output logic event_irq,
    output logic [12:0] system_prescaler,
    // port pins
    input wire logic led_pin_i,
    output logic led_pin_level,
    output logic led_pin_oe_n,
    output logic ext_interrupt_one_sel
);

    // ****************************************
    // bus decode
    // ****************************************
    logic setup_phase;
    logic wr_access;
    logic [7:0] wdata8;
    logic hit_ctrl, hit_stat, hit_p7d, hit_p1f, hit_p7r, hit_sby1, hit_sby2;
    logic hit_evs, hit_eve, hit_evc, hit_slp, hit_mode, hit_any;
    logic [7:0] low_voltage_ctrl;
    logic [7:0] port7_output_data;
    logic [7:0] port1_pin_function;
    logic [7:0] port7_direction;
    logic [7:0] standby_ctrl_primary;
    logic [7:0] standby_ctrl_secondary;
    logic [lvs_pkg::EVT_W-1:0] evt_status;
    logic [lvs_pkg::EVT_W-1:0] evt_enable;
    logic supply_fall_flag;
    logic supply_rise_flag;
    lvs_pkg::lvs_det_e det_state;
    lvs_pkg::lvs_pwr_e pwr_state;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign wdata8 = pwdata[7:0];
    assign hit_ctrl = paddr == {lvs_pkg::IDX_LV_CTRL[29:0], 2'b00};
    assign hit_stat = paddr == {lvs_pkg::IDX_LV_STATUS[29:0], 2'b00};
    assign hit_p7d = paddr == {lvs_pkg::IDX_P7_DATA[29:0], 2'b00};
    assign hit_p1f = paddr == {lvs_pkg::IDX_P1_FUNC[29:0], 2'b00};
    assign hit_p7r = paddr == {lvs_pkg::IDX_P7_DIR[29:0], 2'b00};
    assign hit_sby1 = paddr == {lvs_pkg::IDX_SBY_CTRL1[29:0], 2'b00};
    assign hit_sby2 = paddr == {lvs_pkg::IDX_SBY_CTRL2[29:0], 2'b00};
    assign hit_evs = paddr == {lvs_pkg::IDX_EVT_STATUS[29:0], 2'b00};
    assign hit_eve = paddr == {lvs_pkg::IDX_EVT_ENABLE[29:0], 2'b00};
    assign hit_evc = paddr == {lvs_pkg::IDX_EVT_CLEAR[29:0], 2'b00};
    assign hit_slp = paddr == {lvs_pkg::IDX_SLEEP_CMD[29:0], 2'b00};
    assign hit_mode = paddr == {lvs_pkg::IDX_MODE_STAT[29:0], 2'b00};
    assign hit_any = hit_ctrl | hit_stat | hit_p7d | hit_p1f | hit_p7r | hit_sby1
        | hit_sby2 | hit_evs | hit_eve | hit_evc | hit_slp | hit_mode;

    // zero wait states: read data is caught in the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit_any;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            prdata <= 32'h00000000;
            case (1'b1)
                hit_ctrl: prdata[7:0] <= low_voltage_ctrl;
                hit_stat: prdata[7:0] <= {6'h00, supply_fall_flag, supply_rise_flag};
                hit_p7d: prdata[7:0] <= port7_output_data;
                hit_p1f: prdata[7:0] <= port1_pin_function;
                hit_p7r: prdata[7:0] <= port7_direction;
                hit_sby1: prdata[7:0] <= standby_ctrl_primary;
                hit_sby2: prdata[7:0] <= standby_ctrl_secondary;
                hit_evs: prdata[lvs_pkg::EVT_W-1:0] <= evt_status;
                hit_eve: prdata[lvs_pkg::EVT_W-1:0] <= evt_enable;
                hit_mode: prdata[2:0] <= pwr_state;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // plain control registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_ctrl <= lvs_pkg::REG_RESET;
            port7_output_data <= lvs_pkg::REG_RESET;
            port1_pin_function <= lvs_pkg::REG_RESET;
            port7_direction <= lvs_pkg::REG_RESET;
            standby_ctrl_primary <= lvs_pkg::REG_RESET;
            standby_ctrl_secondary <= lvs_pkg::REG_RESET;
            evt_enable <= '0;
        end else if (wr_access) begin
            if (hit_ctrl) low_voltage_ctrl <= wdata8;
            if (hit_p7d) port7_output_data <= wdata8;
            if (hit_p1f) port1_pin_function <= wdata8;
            if (hit_p7r) port7_direction <= wdata8;
            if (hit_sby1) standby_ctrl_primary <= wdata8;
            if (hit_sby2) standby_ctrl_secondary <= wdata8;
            if (hit_eve) evt_enable <= pwdata[lvs_pkg::EVT_W-1:0];
        end
    end

    // ****************************************
    // prescaler
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_prescaler <= '0;
        end else begin
            system_prescaler <= system_prescaler + 13'h0001;
        end
    end

    // ****************************************
    // detector
    // ****************************************
    logic detector_enable, reset_level_select, undervolt_reset_enable;
    logic fall_irq_enable, rise_irq_enable;
    logic det_on, below_reset, fall_seen, fall_event, rise_event;
    logic clr_fall, clr_rise;

    assign detector_enable = low_voltage_ctrl[lvs_pkg::BIT_DET_EN];
    assign reset_level_select = low_voltage_ctrl[lvs_pkg::BIT_LVL_SEL];
    assign undervolt_reset_enable = low_voltage_ctrl[lvs_pkg::BIT_RST_EN];
    assign fall_irq_enable = low_voltage_ctrl[lvs_pkg::BIT_FALL_IE];
    assign rise_irq_enable = low_voltage_ctrl[lvs_pkg::BIT_RISE_IE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_state <= lvs_pkg::DET_IDLE;
        end else begin
            case (det_state)
                lvs_pkg::DET_IDLE: if (detector_enable) det_state <= lvs_pkg::DET_ACTIVE;
                lvs_pkg::DET_ACTIVE: if (!detector_enable) det_state <= lvs_pkg::DET_IDLE;
                default: det_state <= lvs_pkg::DET_IDLE;
            endcase
        end
    end

    assign det_on = det_state == lvs_pkg::DET_ACTIVE;
    // threshold picks the comparator that sets the reset level
    assign below_reset = det_on && (reset_level_select ? supply_cmp.below_rst_hi
        : supply_cmp.below_rst_lo);
    assign undervolt_reset = below_reset && undervolt_reset_enable;

    // fall seen and not yet followed by reset level: arms the rise flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_seen <= 1'b0;
        end else if (!det_on || below_reset || !rise_irq_enable) begin
            fall_seen <= 1'b0;
        end else if (supply_cmp.below_fall) begin
            fall_seen <= 1'b1;
        end else if (supply_cmp.above_rise) begin
            fall_seen <= 1'b0;
        end
    end

    assign fall_event = det_on && supply_cmp.below_fall;
    assign rise_event = fall_seen && supply_cmp.above_rise && !below_reset;
    // a write of 0 clears the flag; a write of 1 leaves it
    assign clr_fall = wr_access && hit_stat && !wdata8[lvs_pkg::BIT_FALL_FLAG];
    assign clr_rise = wr_access && hit_stat && !wdata8[lvs_pkg::BIT_RISE_FLAG];

    // set wins over clear so a fall at the clear edge is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_fall_flag <= 1'b0;
        end else if (fall_event) begin
            supply_fall_flag <= 1'b1;
        end else if (clr_fall) begin
            supply_fall_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_rise_flag <= 1'b0;
        end else if (rise_event) begin
            supply_rise_flag <= 1'b1;
        end else if (clr_rise) begin
            supply_rise_flag <= 1'b0;
        end
    end

    logic fall_req, rise_req;
    assign fall_req = supply_fall_flag && fall_irq_enable;
    assign rise_req = supply_rise_flag && rise_irq_enable;
    assign ext_interrupt_zero = fall_req || rise_req;

    // ****************************************
    // standby control
    // ****************************************
    logic soft_standby_select, direct_transfer_flag, enter_standby, wake_done;
    logic [2:0] wait_sel;
    logic [lvs_pkg::WAIT_W-1:0] wait_cnt;
    logic [lvs_pkg::WAIT_W-1:0] wait_target;

    assign soft_standby_select = standby_ctrl_primary[lvs_pkg::BIT_SOFT_STANDBY_SELECT];
    assign direct_transfer_flag = standby_ctrl_secondary[lvs_pkg::BIT_DIRECT_TRANSFER_FLAG];
    assign wait_sel = standby_ctrl_primary[lvs_pkg::BIT_STS_HI:lvs_pkg::BIT_STS_LO];
    // one select step doubles the wait; base pattern gives 2**17 cycles
    assign wait_target = lvs_pkg::WAIT_W'(1) << (WAIT_BASE_LOG2 + int'(wait_sel));
    assign enter_standby = (pwr_state == lvs_pkg::PWR_ACTIVE) && sleep_exec
        && soft_standby_select && !direct_transfer_flag;
    assign wake_done = (pwr_state == lvs_pkg::PWR_WAKING)
        && (wait_cnt == wait_target - lvs_pkg::WAIT_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_state <= lvs_pkg::PWR_ACTIVE;
        end else begin
            case (pwr_state)
                lvs_pkg::PWR_ACTIVE: if (enter_standby) pwr_state <= lvs_pkg::PWR_STANDBY;
                lvs_pkg::PWR_STANDBY: if (rise_req) pwr_state <= lvs_pkg::PWR_WAKING;
                lvs_pkg::PWR_WAKING: if (wake_done) pwr_state <= lvs_pkg::PWR_ACTIVE;
                default: pwr_state <= lvs_pkg::PWR_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= '0;
        end else if (pwr_state == lvs_pkg::PWR_WAKING) begin
            wait_cnt <= wait_cnt + lvs_pkg::WAIT_W'(1);
        end else begin
            wait_cnt <= '0;
        end
    end

    // oscillator still counts the wake wait, so standby covers both states
    assign standby_mode = pwr_state != lvs_pkg::PWR_ACTIVE;

    // ****************************************
    // event interrupt
    // ****************************************
    logic [lvs_pkg::EVT_W-1:0] evt_set;
    logic [lvs_pkg::EVT_W-1:0] evt_clr;
    assign evt_set = {wake_done, enter_standby, rise_event, fall_event};
    assign evt_clr = (wr_access && hit_evc) ? pwdata[lvs_pkg::EVT_W-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < lvs_pkg::EVT_W; gi++) begin : g_evt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    evt_status[gi] <= 1'b0;
                end else if (evt_set[gi]) begin
                    evt_status[gi] <= 1'b1;
                end else if (evt_clr[gi]) begin
                    evt_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign event_irq = |(evt_status & evt_enable);

    // ****************************************
    // port pins
    // ****************************************
    assign led_pin_level = port7_output_data[lvs_pkg::BIT_LED];
    assign led_pin_oe_n = !port7_direction[lvs_pkg::BIT_LED];
    // cleared keeps the shared pin a general port pin
    assign ext_interrupt_one_sel = port1_pin_function[lvs_pkg::BIT_P15_FUNC];

    // ****************************************
    // checks
    // ****************************************
    logic led_in_unused;
    assign led_in_unused = led_pin_i;

    // first edge after release has no counted step behind it
    prescale_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> system_prescaler == $past(system_prescaler) + 13'h0001)
        else $error("prescaler did not step by one");

    det_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !detector_enable |=> !det_on)
        else $error("detector active while disabled");

    reset_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (det_on && undervolt_reset_enable && !reset_level_select && supply_cmp.below_rst_lo)
        |-> undervolt_reset)
        else $error("low reset level not honoured");

    reset_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !undervolt_reset_enable |-> !undervolt_reset)
        else $error("reset while gated off");

    fall_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        fall_event |=> supply_fall_flag)
        else $error("fall flag not set");

    rise_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(supply_rise_flag) |-> $past(fall_seen) && $past(supply_cmp.above_rise))
        else $error("rise flag without fall and recovery");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        supply_fall_flag && !clr_fall |=> supply_fall_flag)
        else $error("fall flag dropped without clear");

    irq_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_interrupt_zero == ((supply_fall_flag && fall_irq_enable)
        || (supply_rise_flag && rise_irq_enable)))
        else $error("interrupt zero mismatch");

    wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_state == lvs_pkg::PWR_STANDBY) && rise_req |=> pwr_state == lvs_pkg::PWR_WAKING)
        else $error("rise did not start wake");

    standby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        enter_standby |=> standby_mode ##0 evt_status[lvs_pkg::EVT_STANDBY])
        else $error("standby not entered");

    led_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_p7d |=> led_pin_level == $past(wdata8[lvs_pkg::BIT_LED]))
        else $error("led level not written");

    fall_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fall_irq_enable && !supply_rise_flag |-> !ext_interrupt_zero)
        else $error("fall request while disabled");

    rise_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rise_irq_enable && !supply_fall_flag |-> !ext_interrupt_zero)
        else $error("rise request while disabled");

    led_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        led_pin_oe_n != port7_direction[lvs_pkg::BIT_LED])
        else $error("led direction mismatch");

    standby_cov: cover property (@(posedge pclk) disable iff (!presetn) enter_standby);
    uv_reset_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(undervolt_reset));
    fall_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(supply_fall_flag));
    rise_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(supply_rise_flag));
    wake_cov: cover property (@(posedge pclk) disable iff (!presetn) wake_done);

endmodule // lvs_top

// ### lvs_top_tb.sv
// testbench for lvs_top: apb registers, supply flags, reset level, standby, port pins
// assumes lvs_pkg and a short wake wait (WAIT_BASE_LOG2 = 2, pattern 100 gives 64 cycles)
`timescale 1ns/1ps
module lvs_top_tb;
    // ****************************************
    // signals
    // ****************************************
    logic pclk, presetn, psel, penable, pwrite, sleep_exec, led_pin_i;
    logic [31:0] paddr, pwdata, prdata;
    logic pready, pslverr, undervolt_reset, ext_interrupt_zero, standby_mode, event_irq;
    logic led_pin_level, led_pin_oe_n, ext_interrupt_one_sel;
    logic [12:0] system_prescaler;
    lvs_pkg::lvs_cmp_s cmp;
    int err_total, samples_checked, cycles;

    lvs_top #(.WAIT_BASE_LOG2(2)) u_lvs_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_cmp(cmp), .sleep_exec(sleep_exec),
        .undervolt_reset(undervolt_reset), .ext_interrupt_zero(ext_interrupt_zero),
        .standby_mode(standby_mode), .event_irq(event_irq), .system_prescaler(system_prescaler),
        .led_pin_i(led_pin_i), .led_pin_level(led_pin_level), .led_pin_oe_n(led_pin_oe_n),
        .ext_interrupt_one_sel(ext_interrupt_one_sel));

    // ****************************************
    // common tasks
    // ****************************************
    task automatic results();
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // every call starts with an edge, so strobes are never reassigned in one step
    task automatic apb(input logic wr, input logic [31:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= idx << 2;
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdchk(input logic [31:0] idx, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic drive_cmp(input logic [3:0] v, input int n);
        @(posedge pclk);
        cmp <= v;
        cyc(n);
        cmp <= 4'h0;
        cyc(2);
    endtask

    task automatic sleep_pulse();
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
        cyc(2);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_vals();
        rdchk(lvs_pkg::IDX_LV_CTRL, 32'h0, 1'b0);
        rdchk(lvs_pkg::IDX_LV_STATUS, 32'h0, 1'b0);
        chk({31'h0, led_pin_oe_n}, 32'h1);
        rdchk(32'h00000010, 32'h0, 1'b1);
    endtask

    // 8200 cycles crosses one full wrap of the 13-bit count
    task automatic t_prescale();
        logic [12:0] p0;
        p0 = system_prescaler;
        cyc(8200);
        chk({19'h0, system_prescaler}, {19'h0, 13'(p0 + 13'h0008)});
    endtask

    task automatic t_ports();
        wr(lvs_pkg::IDX_P7_DATA, 8'h10);
        wr(lvs_pkg::IDX_P7_DIR, 8'h10);
        wr(lvs_pkg::IDX_P1_FUNC, 8'h20);
        cyc(2);
        chk({31'h0, led_pin_level}, 32'h1);
        chk({31'h0, led_pin_oe_n}, 32'h0);
        chk({31'h0, ext_interrupt_one_sel}, 32'h1);
        wr(lvs_pkg::IDX_P7_DATA, 8'h00);
        wr(lvs_pkg::IDX_P7_DIR, 8'h00);
        wr(lvs_pkg::IDX_P1_FUNC, 8'h00);
        cyc(2);
        chk({30'h0, led_pin_level, led_pin_oe_n}, 32'h1);
        chk({31'h0, ext_interrupt_one_sel}, 32'h0);
    endtask

    task automatic t_flags();
        wr(lvs_pkg::IDX_LV_CTRL, 8'h03);
        drive_cmp(4'h8, 2);
        rdchk(lvs_pkg::IDX_LV_STATUS, 32'h0, 1'b0);
        wr(lvs_pkg::IDX_LV_CTRL, 8'h80);
        drive_cmp(4'h8, 2);
        rdchk(lvs_pkg::IDX_LV_STATUS, 32'h2, 1'b0);
        chk({31'h0, ext_interrupt_zero}, 32'h0);
        wr(lvs_pkg::IDX_LV_CTRL, 8'h82);
        drive_cmp(4'h4, 2);
        chk({31'h0, ext_interrupt_zero}, 32'h1);
        rdchk(lvs_pkg::IDX_LV_STATUS, 32'h2, 1'b0);
        wr(lvs_pkg::IDX_LV_STATUS, 8'h00);
        cyc(2);
        chk({31'h0, ext_interrupt_zero}, 32'h0);
        wr(lvs_pkg::IDX_LV_CTRL, 8'h83);
        drive_cmp(4'h8, 2);
        drive_cmp(4'h4, 2);
        rdchk(lvs_pkg::IDX_LV_STATUS, 32'h3, 1'b0);
        wr(lvs_pkg::IDX_LV_STATUS, 8'h01);
        wr(lvs_pkg::IDX_LV_CTRL, 8'h81);
        rdchk(lvs_pkg::IDX_LV_STATUS, 32'h1, 1'b0);
        chk({31'h0, ext_interrupt_zero}, 32'h1);
        wr(lvs_pkg::IDX_LV_CTRL, 8'h80);
        cyc(2);
        chk({31'h0, ext_interrupt_zero}, 32'h0);
        wr(lvs_pkg::IDX_LV_STATUS, 8'h00);
    endtask

    // the comparator level is held, not pulsed, while the reset output is looked at
    task automatic t_reset_level();
        wr(lvs_pkg::IDX_LV_CTRL, 8'h84);
        @(posedge pclk);
        cmp <= 4'h9;
        cyc(3);
        chk({31'h0, undervolt_reset}, 32'h0);
        cmp <= 4'hB;
        cyc(3);
        chk({31'h0, undervolt_reset}, 32'h1);
        cmp <= 4'h9;
        wr(lvs_pkg::IDX_LV_CTRL, 8'h8C);
        cyc(2);
        chk({31'h0, undervolt_reset}, 32'h1);
        wr(lvs_pkg::IDX_LV_CTRL, 8'h88);
        cyc(2);
        chk({31'h0, undervolt_reset}, 32'h0);
        cmp <= 4'h0;
        wr(lvs_pkg::IDX_LV_STATUS, 8'h00);
    endtask

    task automatic t_standby();
        int n;
        wr(lvs_pkg::IDX_LV_CTRL, 8'h81);
        wr(lvs_pkg::IDX_SBY_CTRL1, 8'hC0);
        wr(lvs_pkg::IDX_SBY_CTRL2, 8'h20);
        sleep_pulse();
        chk({31'h0, standby_mode}, 32'h0);
        wr(lvs_pkg::IDX_SBY_CTRL2, 8'h00);
        sleep_pulse();
        chk({31'h0, standby_mode}, 32'h1);
        rdchk(lvs_pkg::IDX_MODE_STAT, 32'h2, 1'b0);
        drive_cmp(4'h8, 2);
        chk({31'h0, standby_mode}, 32'h1);
        @(posedge pclk);
        cmp <= 4'h4;
        @(posedge pclk);
        cmp <= 4'h0;
        n = 0;
        while (standby_mode !== 1'b0 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, 1'(n >= 64 && n <= 70)}, 32'h1);
        rdchk(lvs_pkg::IDX_MODE_STAT, 32'h1, 1'b0);
    endtask

    task automatic t_events();
        rdchk(lvs_pkg::IDX_EVT_STATUS, 32'hF, 1'b0);
        wr(lvs_pkg::IDX_EVT_ENABLE, 8'h08);
        cyc(2);
        chk({31'h0, event_irq}, 32'h1);
        wr(lvs_pkg::IDX_EVT_ENABLE, 8'h00);
        cyc(2);
        chk({31'h0, event_irq}, 32'h0);
        wr(lvs_pkg::IDX_EVT_ENABLE, 8'h0F);
        wr(lvs_pkg::IDX_EVT_CLEAR, 8'h0F);
        cyc(2);
        chk({31'h0, event_irq}, 32'h0);
        rdchk(lvs_pkg::IDX_EVT_STATUS, 32'h0, 1'b0);
    endtask

    // ****************************************
    // clock, timeout and main sequence
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // the whole run needs roughly 8500 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            results();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        sleep_exec = 1'b0;
        led_pin_i = 1'b0;
        cmp = 4'h0;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        cyc(16);
        presetn <= 1'b1;
        t_reset_vals();
        t_prescale();
        t_ports();
        t_flags();
        t_reset_level();
        t_standby();
        t_events();
        results();
    end
endmodule // lvs_top_tb
